// ---- bench/sdm_host_src.sv ----
// Purpose: Host serializer model feeding the equalized input.
// Assumes: Signal presence shows as the detector's raw level.
// Notes:   A slow source needs eight cycles to reach full swing.
`timescale 1ns/100ps
module sdm_host_src (
    // Clock.
    input  wire logic clk_sys,
    // Bench control.
    input  wire logic send,
    input  wire logic slow,
    // Detector level.
    output logic      signal_detect_raw
);
    logic [2:0] ramp_ff = 3'h0;
    initial signal_detect_raw = 1'b0;
    always @(posedge clk_sys) begin
        ramp_ff <= !send ? 3'h0 : (slow && ramp_ff != 3'h7) ? ramp_ff + 3'h1 : 3'h7;
        signal_detect_raw <= send && (!slow || ramp_ff == 3'h7);
    end
endmodule : sdm_host_src

// ---- bench/sdm_mode_chk.sv ----
// Purpose: Port checks of the mode control block.
// Assumes: One clock; pin changes reach the mode register in three edges.
// Notes:   Bound to every instance of the block.
`timescale 1ns/100ps
module sdm_mode_chk (
    // Clock and reset.
    input wire logic               clk_sys,
    input wire logic               reset,
    // Pins and register port.
    input wire logic               enable_pin,
    input wire logic               signal_detect_raw,
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_rdata,
    // Watched outputs.
    input wire logic               primary_line_output_en,
    input wire logic               detector_power_en,
    input wire logic               serial_if_power_en,
    input wire sdm_pkg::sdm_mode_t mode,
    input wire logic               detect_flag_n_oe,
    input wire logic               irq
);
    import sdm_pkg::*;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////
    serial_alive_a: assert property (serial_if_power_en) else $error("serial unpowered");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
    down_dark_a: assert property (mode == SDM_MODE_DOWN |-> !detector_power_en && !primary_line_output_en)
        else $error("power in down mode");
    save_watch_a: assert property (mode == SDM_MODE_SAVE |-> detector_power_en && !primary_line_output_en)
        else $error("save mode power wrong");
    primary_route_a: assert property (primary_line_output_en == (mode == SDM_MODE_NORMAL))
        else $error("primary enable wrong");
    force_down_a: assert property (!enable_pin [*3] |=> mode == SDM_MODE_DOWN) else $error("no power down");
    go_normal_a: assert property ((enable_pin && signal_detect_raw) [*3] |=> mode == SDM_MODE_NORMAL)
        else $error("no normal mode");
    go_save_a: assert property ((enable_pin && !signal_detect_raw) [*3] |=> mode == SDM_MODE_SAVE)
        else $error("no save mode");
    flag_low_a: assert property ((enable_pin && signal_detect_raw) [*4] |=> detect_flag_n_oe)
        else $error("flag not driven");
    flag_off_a: assert property (mode == SDM_MODE_DOWN && $past(mode) == SDM_MODE_DOWN |-> !detect_flag_n_oe)
        else $error("flag driven in down mode");
    cov_save: cover property (mode == SDM_MODE_NORMAL ##1 mode == SDM_MODE_SAVE);
    cov_wake: cover property (mode == SDM_MODE_SAVE ##1 mode == SDM_MODE_NORMAL);
    cov_irq: cover property ($rose(irq));
endmodule : sdm_mode_chk

bind sdm_mode_ctrl sdm_mode_chk i_chk (.clk_sys, .reset, .enable_pin, .signal_detect_raw, .reg_rd, .reg_rdata,
    .primary_line_output_en, .detector_power_en, .serial_if_power_en, .mode, .detect_flag_n_oe, .irq);

// ---- bench/tb_top.sv ----
// Purpose: Self-checking bench of the mode control block.
// Assumes: Straps are sampled once after each reset.
// Notes:   Random values come from a bench shift register.
`timescale 1ns/100ps
module tb_top;
    import sdm_pkg::*;
    logic        clk_sys = 1'b0, reset = 1'b1, enable_pin = 1'b0, send = 1'b0, slow = 1'b0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, det, prim, dpw, dtw, sew, fo, oe, irq, en;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, rdata, v, w, lfsr = 32'h0001_6AE9;
    logic [1:0]  b, s, l;
    sdm_cmp_t    lb_cmp = 3'h0, sec_cmp = 3'h0, eq_cmp = 3'h0;
    sdm_cfg_t    cfg;
    sdm_mode_t   mode, pm, md;
    int          n_mismatch = 0, n_tests = 0, cycles = 0;

    sdm_host_src i_src (.clk_sys(clk_sys), .send(send), .slow(slow), .signal_detect_raw(det));
    sdm_mode_ctrl i_dut (.clk_sys(clk_sys), .reset(reset), .loopback_route_select_cmp(lb_cmp),
        .second_line_route_select_cmp(sec_cmp), .input_boost_strap_cmp(eq_cmp), .enable_pin(enable_pin),
        .signal_detect_raw(det), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(rdata), .cfg(cfg), .primary_line_output_en(prim), .detector_power_en(dtw),
        .datapath_power_en(dpw), .serial_if_power_en(sew), .mode(mode), .detect_flag_n_out(fo),
        .detect_flag_n_oe(oe), .irq(irq));

    ////////////////////////////////////////////////////////////////
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    function automatic sdm_cmp_t cmp_of(logic [1:0] x);
        return {x == 2'h3, x[1], x != 2'h0};
    endfunction : cmp_of
    function automatic logic [7:0] exp_eq(logic [1:0] x);
        return x == 2'h0 ? 8'h90 : x == 2'h1 ? 8'h80 : 8'h00;
    endfunction : exp_eq
    // Settled events of one move: mode change, signal lost, signal found.
    function automatic logic [31:0] exp_irq(sdm_mode_t p, sdm_mode_t m);
        return {29'h0, p != m, p == SDM_MODE_NORMAL && m != SDM_MODE_NORMAL,
                p != SDM_MODE_NORMAL && m == SDM_MODE_NORMAL};
    endfunction : exp_irq
    // Power enables in the order primary, detector, datapath, serial.
    function automatic logic [3:0] exp_pwr(sdm_mode_t m);
        return m == SDM_MODE_NORMAL ? 4'hF : m == SDM_MODE_SAVE ? 4'h5 : 4'h1;
    endfunction : exp_pwr

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [3:0] a, logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd
    task automatic pins(logic en, logic sn, logic sl, sdm_mode_t m);
        @(posedge clk_sys);
        enable_pin <= en;
        send <= sn;
        slow <= sl;
        for (int i = 0; i < 20 && mode !== m; i++) @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        #1 chk(mode, m);
        chk({prim, dtw, dpw, sew}, exp_pwr(m));
    endtask : pins
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 8; i++) begin
            w = rnd();
            {b, s, l} = i < 4 ? {2'(i), 2'(3 - i), 2'(i)} : w[5:0];
            @(posedge clk_sys);
            reset <= 1'b1;
            lb_cmp <= cmp_of(l);
            sec_cmp <= cmp_of(s);
            eq_cmp <= cmp_of(b);
            repeat (i == 0 ? 10 : 2) @(posedge clk_sys);
            reset <= 1'b0;
            repeat (6) @(posedge clk_sys);
            eq_cmp <= cmp_of(~b);
            #1 chk(cfg, {1'b1, exp_eq(b), b, s == 2'h0, l == 2'h0});
            rd(SDM_REG_STRAPS, {b, s, l});
            rd(SDM_REG_CTRL, 32'h04);
            rd(SDM_REG_BOOST, 32'h0);
            rd(SDM_REG_IRQ_MASK, 32'h0);
            wr(4'hF, w);
            rd(4'hF, 32'h0);
            chk(cfg.eq_boost, exp_eq(b));
        end
        for (int k = 0; k < 2; k++) begin
            w = rnd();
            v = {24'h0, w[9:8], 1'b1, w[10], w[11], k[0], 2'h3};
            wr(SDM_REG_BOOST, {24'h0, w[7:0]});
            wr(SDM_REG_CTRL, v);
            rd(SDM_REG_CTRL, v);
            chk(cfg, {k[0], w[7:0], w[9:8], w[11], w[10]});
            wr(SDM_REG_CTRL, 32'h04);
            repeat (2) @(posedge clk_sys);
            #1 chk(cfg, {1'b1, exp_eq(b), b, s == 2'h0, l == 2'h0});
        end
        wr(SDM_REG_IRQ_MASK, 32'h7);
        rd(SDM_REG_IRQ_STAT, 32'h0);
        pins(1'b1, 1'b1, 1'b0, SDM_MODE_NORMAL);
        chk({oe, fo, irq}, 3'b101);
        rd(SDM_REG_STATUS, 32'h3);
        rd(SDM_REG_IRQ_STAT, 32'h5);
        rd(SDM_REG_IRQ_STAT, 32'h0);
        chk(irq, 1'b0);
        pins(1'b1, 1'b0, 1'b1, SDM_MODE_SAVE);
        chk({oe, irq}, 2'b01);
        rd(SDM_REG_STATUS, 32'h6);
        rd(SDM_REG_IRQ_STAT, 32'h6);
        wr(SDM_REG_IRQ_MASK, 32'h2);
        pins(1'b1, 1'b1, 1'b1, SDM_MODE_NORMAL);
        chk(irq, 1'b0);
        rd(SDM_REG_IRQ_STAT, 32'h5);
        pins(1'b0, 1'b1, 1'b0, SDM_MODE_DOWN);
        chk(oe, 1'b0);
        pins(1'b0, 1'b0, 1'b0, SDM_MODE_DOWN);
        chk(irq, 1'b1);
        rd(SDM_REG_IRQ_STAT, 32'h6);
        pm = SDM_MODE_DOWN;
        wr(SDM_REG_IRQ_MASK, 32'h7);
        for (int j = 0; j < 30; j++) begin
            v = rnd();
            en = v[0] | v[1];
            md = !en ? SDM_MODE_DOWN : v[2] ? SDM_MODE_NORMAL : SDM_MODE_SAVE;
            wr(SDM_REG_BOOST, {24'h0, v[15:8]});
            rd(SDM_REG_BOOST, {24'h0, v[15:8]});
            pins(en, v[2], v[3], md);
            chk(irq, exp_irq(pm, md) != 32'h0);
            rd(SDM_REG_STATUS, {28'h0, md, en, md == SDM_MODE_NORMAL});
            rd(SDM_REG_IRQ_STAT, exp_irq(pm, md));
            chk(irq, 1'b0);
            pm = md;
        end
        end_sim();
    end
endmodule : tb_top

// ---- design/sdm_mode_ctrl.sv ----
// Purpose: Strap decode, route select, equalizer boost and power mode control.
// Assumes: Comparator and detector inputs are asynchronous and are synchronised here.
// Notes:   Register read data stands in the cycle after the read strobe.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Each four-level pin decodes to low, R, F or high at 0.2, 0.5, 0.8 supply.
// - An open pin biases to two thirds supply and decodes as F.
// - Primary always carries input; secondary and loopback enabled only when select is low. Here primary is enabled in normal mode only.
// - Signal detected with enable high gives normal operation.
// - Enable high and no signal enters power save automatically.
// - Signal detected in power save returns to normal automatically.
// - Enable low forces power-down regardless of signal.
// - Power save keeps detector and serial interface running.
// - Power-down keeps only serial interface running and ignores input.
// - Signal detect state readable on status pin and status register.
// - Equalizer uses manual adapt mode with fixed boost from strap or register.
// - Boost strap high or F gives 0x00, R gives 0x80, low gives 0x90.
// - Registers can override strap-selected adapt mode and boost.
// - Boost strap also selects loopback amplitude and de-emphasis.
// - Active-low status pin goes low once a valid signal is detected.
module sdm_mode_ctrl (
    // Clock and reset.
    input  wire logic                      clk_sys,
    input  wire logic                      reset,
    // Strap comparators.
    input  wire sdm_pkg::sdm_cmp_t         loopback_route_select_cmp,
    input  wire sdm_pkg::sdm_cmp_t         second_line_route_select_cmp,
    input  wire sdm_pkg::sdm_cmp_t         input_boost_strap_cmp,
    // Pins and detector.
    input  wire logic                      enable_pin,
    input  wire logic                      signal_detect_raw,
    // Register port.
    input  wire logic [3:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [31:0]                    reg_rdata,
    // Settings and power controls.
    output sdm_pkg::sdm_cfg_t              cfg,
    output logic                           primary_line_output_en,
    output logic                           detector_power_en,
    output logic                           datapath_power_en,
    output logic                           serial_if_power_en,
    output sdm_pkg::sdm_mode_t             mode,
    // Status pin, open drain, and interrupt.
    output logic                           detect_flag_n_out,
    output logic                           detect_flag_n_oe,
    output logic                           irq
);
    import sdm_pkg::*;

    // Three-bit comparator vector to a level; open pin sits at 2/3 so lands in F.
    function automatic sdm_level_t decode_level(input sdm_cmp_t c);
        if (c.above_80) begin
            decode_level = SDM_LVL_HIGH;
        end else if (c.above_50) begin
            decode_level = SDM_LVL_F;
        end else if (c.above_20) begin
            decode_level = SDM_LVL_R;
        end else begin
            decode_level = SDM_LVL_LOW;
        end
    endfunction : decode_level

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers.
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;

    assign async_in = {loopback_route_select_cmp, second_line_route_select_cmp,
                       input_boost_strap_cmp, enable_pin, signal_detect_raw};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                end else begin
                    sync1_ff[gi] <= async_in[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    logic enable_s;
    logic detect_s;
    assign enable_s = sync2_ff[1];
    assign detect_s = sync2_ff[0];

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture, once after reset release, then held.
    sdm_level_t lb_sel_ff;
    sdm_level_t sec_sel_ff;
    sdm_level_t boost_ff;
    logic [1:0] strap_wait_ff;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            strap_wait_ff <= 2'h0;
            lb_sel_ff     <= SDM_LVL_F;
            sec_sel_ff    <= SDM_LVL_F;
            boost_ff      <= SDM_LVL_F;
        end else if (strap_wait_ff != 2'h3) begin
            strap_wait_ff <= strap_wait_ff + 2'h1;
            if (strap_wait_ff == 2'h2) begin
                lb_sel_ff  <= decode_level(sdm_cmp_t'(sync2_ff[10:8]));
                sec_sel_ff <= decode_level(sdm_cmp_t'(sync2_ff[7:5]));
                boost_ff   <= decode_level(sdm_cmp_t'(sync2_ff[4:2]));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [SDM_CTRL_W-1:0] ctrl_ff;
    logic [7:0]            boost_reg_ff;
    logic [SDM_IRQ_W-1:0]  irq_stat_ff;
    logic [SDM_IRQ_W-1:0]  irq_mask_ff;
    logic [SDM_IRQ_W-1:0]  irq_event;
    logic                  detect_d_ff;
    sdm_mode_t             mode_ff;
    sdm_mode_t             nxt_mode;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_ff      <= SDM_CTRL_RST;
            boost_reg_ff <= SDM_BOOST_RST;
            irq_mask_ff  <= SDM_MASK_RST;
        end else if (reg_wr) begin
            if (reg_addr == SDM_REG_CTRL) begin
                ctrl_ff <= reg_wdata[SDM_CTRL_W-1:0];
            end
            if (reg_addr == SDM_REG_BOOST) begin
                boost_reg_ff <= reg_wdata[7:0];
            end
            if (reg_addr == SDM_REG_IRQ_MASK) begin
                irq_mask_ff <= reg_wdata[SDM_IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power mode machine.
    always_comb begin
        if (!enable_s) begin
            nxt_mode = SDM_MODE_DOWN;
        end else if (detect_s) begin
            nxt_mode = SDM_MODE_NORMAL;
        end else begin
            nxt_mode = SDM_MODE_SAVE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_ff <= SDM_MODE_DOWN;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    assign mode = mode_ff;

    always_comb begin
        detector_power_en  = 1'b0;
        datapath_power_en  = 1'b0;
        serial_if_power_en = 1'b1;
        unique case (mode_ff)
            SDM_MODE_NORMAL: begin
                detector_power_en = 1'b1;
                datapath_power_en = 1'b1;
            end
            SDM_MODE_SAVE: begin
                detector_power_en = 1'b1;
            end
            SDM_MODE_DOWN: begin
                detector_power_en = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Detect flag, events and interrupt.
    logic detect_q;
    assign detect_q = detect_s && (mode_ff != SDM_MODE_DOWN);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            detect_d_ff <= 1'b0;
        end else begin
            detect_d_ff <= detect_q;
        end
    end

    assign irq_event[SDM_IRQ_FOUND] = detect_q && !detect_d_ff;
    assign irq_event[SDM_IRQ_LOST]  = !detect_q && detect_d_ff;
    assign irq_event[SDM_IRQ_MODE]  = (nxt_mode != mode_ff);

    // A read clears the status, but an event in the same cycle still sets it.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_stat_ff <= '0;
        end else if (reg_rd && reg_addr == SDM_REG_IRQ_STAT) begin
            irq_stat_ff <= irq_event;
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_event;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // Open drain: pin pulled low while a signal is detected.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            detect_flag_n_oe <= 1'b0;
        end else begin
            detect_flag_n_oe <= detect_q;
        end
    end

    assign detect_flag_n_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Settings with overrides.
    sdm_cfg_t nxt_cfg;

    always_comb begin
        nxt_cfg.manual_adapt_mode = 1'b1;
        unique case (boost_ff)
            SDM_LVL_HIGH, SDM_LVL_F: nxt_cfg.eq_boost = SDM_EQ_HF;
            SDM_LVL_R:               nxt_cfg.eq_boost = SDM_EQ_R;
            SDM_LVL_LOW:             nxt_cfg.eq_boost = SDM_EQ_LOW;
        endcase
        nxt_cfg.loopback_drive_sel = boost_ff;
        nxt_cfg.secondary_en = (sec_sel_ff == SDM_LVL_LOW);
        nxt_cfg.loopback_en  = (lb_sel_ff == SDM_LVL_LOW);
        if (ctrl_ff[SDM_CTRL_OVR_EQ]) begin
            nxt_cfg.manual_adapt_mode = ctrl_ff[SDM_CTRL_MAN_MODE];
            nxt_cfg.eq_boost          = boost_reg_ff;
        end
        if (ctrl_ff[SDM_CTRL_OVR_ROUTE]) begin
            nxt_cfg.secondary_en = ctrl_ff[SDM_CTRL_SEC_EN];
            nxt_cfg.loopback_en  = ctrl_ff[SDM_CTRL_LB_EN];
        end
        if (ctrl_ff[SDM_CTRL_OVR_LBDRV]) begin
            nxt_cfg.loopback_drive_sel = ctrl_ff[SDM_CTRL_LBDRV_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg <= '0;
        end else begin
            cfg <= nxt_cfg;
        end
    end

    assign primary_line_output_en = datapath_power_en;

    ////////////////////////////////////////////////////////////////////////////
    // Read data.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                SDM_REG_STATUS:   reg_rdata <= {28'h0, mode_ff, enable_s, detect_q};
                SDM_REG_CTRL:     reg_rdata <= {24'h0, ctrl_ff};
                SDM_REG_BOOST:    reg_rdata <= {24'h0, boost_reg_ff};
                SDM_REG_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_ff};
                SDM_REG_IRQ_MASK: reg_rdata <= {29'h0, irq_mask_ff};
                SDM_REG_STRAPS:   reg_rdata <= {26'h0, boost_ff, sec_sel_ff, lb_sel_ff};
                default:          reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule : sdm_mode_ctrl

// ---- design/sdm_pkg.sv ----
// Purpose: Shared constants and types for the cable driver mode control block.
// Assumes: One 250 MHz clock, synchronous active-high reset.
// Notes:   Register offsets are word indices on the plain register port.
package sdm_pkg;

    // Four-level strap states.
    typedef enum logic [1:0] {
        SDM_LVL_LOW  = 2'h0,
        SDM_LVL_R    = 2'h1,
        SDM_LVL_F    = 2'h2,
        SDM_LVL_HIGH = 2'h3
    } sdm_level_t;

    typedef enum logic [1:0] {
        SDM_MODE_NORMAL,
        SDM_MODE_SAVE,
        SDM_MODE_DOWN
    } sdm_mode_t;

    // Comparator outputs of one four-level pin: above 0.2, 0.5 and 0.8 of supply.
    typedef struct packed {
        logic above_80;
        logic above_50;
        logic above_20;
    } sdm_cmp_t;

    // Settings produced for the analog blocks.
    typedef struct packed {
        logic       manual_adapt_mode;
        logic [7:0] eq_boost;
        logic [1:0] loopback_drive_sel;
        logic       secondary_en;
        logic       loopback_en;
    } sdm_cfg_t;

    localparam int          SDM_ADDR_W        = 4;
    localparam int          SDM_DATA_W        = 32;
    localparam logic [3:0]  SDM_REG_STATUS    = 4'h0;
    localparam logic [3:0]  SDM_REG_CTRL      = 4'h1;
    localparam logic [3:0]  SDM_REG_BOOST     = 4'h2;
    localparam logic [3:0]  SDM_REG_IRQ_STAT  = 4'h3;
    localparam logic [3:0]  SDM_REG_IRQ_MASK  = 4'h4;
    localparam logic [3:0]  SDM_REG_STRAPS    = 4'h5;

    // Control register fields.
    localparam int SDM_CTRL_OVR_EQ    = 0;
    localparam int SDM_CTRL_OVR_ROUTE = 1;
    localparam int SDM_CTRL_MAN_MODE  = 2;
    localparam int SDM_CTRL_SEC_EN    = 3;
    localparam int SDM_CTRL_LB_EN     = 4;
    localparam int SDM_CTRL_OVR_LBDRV = 5;
    localparam int SDM_CTRL_LBDRV_LSB = 6;
    localparam int SDM_CTRL_W         = 8;

    // Interrupt status fields: signal found, signal lost, mode change.
    localparam int SDM_IRQ_W         = 3;
    localparam int SDM_IRQ_FOUND     = 0;
    localparam int SDM_IRQ_LOST      = 1;
    localparam int SDM_IRQ_MODE      = 2;

    localparam logic [SDM_CTRL_W-1:0] SDM_CTRL_RST  = 8'h04;
    localparam logic [7:0]            SDM_BOOST_RST = 8'h00;
    localparam logic [SDM_IRQ_W-1:0]  SDM_MASK_RST  = 3'h0;

    localparam logic [7:0] SDM_EQ_HF  = 8'h00;
    localparam logic [7:0] SDM_EQ_R   = 8'h80;
    localparam logic [7:0] SDM_EQ_LOW = 8'h90;

endpackage : sdm_pkg
